// file: core/fwp_defines.svh
`ifndef FWP_DEFINES_SVH
`define FWP_DEFINES_SVH

// ----------------------------------------------------------------
// Flash geometry
// ----------------------------------------------------------------
`define FWP_ADDR_W       24
`define FWP_PAGE_LSB     12
`define FWP_PAGE_W       (`FWP_ADDR_W - `FWP_PAGE_LSB)
`define FWP_ROW_LSB      10
`define FWP_ROWS_PER_PG  4
`define FWP_ROW_QUADS    64
`define FWP_ROW_WORDS    256
`define FWP_QUAD_W       128
`define FWP_WORD_W       32
`define FWP_BOOT_PAGES   8
`define FWP_BOOT_IDX_W   3

// ----------------------------------------------------------------
// Protection register fields and reset values
// ----------------------------------------------------------------
`define FWP_LOCK_BIT     31
`define FWP_BOOT_RST     8'hff
`define FWP_BELOW_RST    12'h000
`define FWP_ABOVE_RST    12'hfff

// ----------------------------------------------------------------
// Bus encodings
// ----------------------------------------------------------------
`define FWP_HTRANS_IDLE  2'h0
`define FWP_HTRANS_NSEQ  2'h2
`define FWP_HSIZE_WORD   3'h2
`define FWP_HBURST_SGL   3'h0

`endif

// file: core/fwp_pkg.sv
package fwp_pkg;

  typedef enum logic [1:0] {
    op_row,
    op_quad,
    op_word,
    op_erase
  } fwp_op_type;

  typedef enum logic [1:0] {
    st_idle,
    st_fetch_addr,
    st_fetch_data,
    st_flash
  } fwp_state_type;

endpackage : fwp_pkg

// file: core/fwp_protect_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "fwp_defines.svh"

module fwp_protect_check
  import fwp_pkg::*;
(
  // Target of the operation
  input  wire logic [`FWP_ADDR_W-1:0]     addr,
  input  wire logic                       in_boot,
  // Protection settings
  input  wire logic [`FWP_BOOT_PAGES-1:0] boot_prot,
  input  wire logic [`FWP_PAGE_W-1:0]     below_page,
  input  wire logic [`FWP_PAGE_W-1:0]     above_page,
  // Verdict
  output logic                            prot_hit
);

  logic [`FWP_BOOT_PAGES-1:0] boot_hit;
  logic [`FWP_PAGE_W-1:0]     page;
  logic                       prog_hit;

  assign page = addr[`FWP_ADDR_W-1:`FWP_PAGE_LSB]; // R13

  genvar i;
  for (i = 0; i < `FWP_BOOT_PAGES; i++) begin : g_boot
    assign boot_hit[i] = boot_prot[i] &&
      (addr[`FWP_PAGE_LSB +: `FWP_BOOT_IDX_W] == `FWP_BOOT_IDX_W'(i)); // R7
  end

  // All ones in the upper bound means the bound is switched off, so
  // the topmost page is not caught by its own reset value.
  assign prog_hit = (page < below_page) || // R11
                    ((page >= above_page) && !(&above_page)); // R12 R14

  assign prot_hit = in_boot ? (|boot_hit) : prog_hit;

endmodule : fwp_protect_check

`default_nettype wire

// file: core/fwp_flash_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "fwp_defines.svh"

// Function
// R1 - Erase always covers one whole page
// R2 - Page is four rows; row is 64 quads
// R3 - Program by row, quad word, or word
// R4 - Flash accessed 128 bits; row is 1 KB
// R5 - Commands and configuration come through ports
// R6 - Row data fetched from SRAM as initiator
// R7 - Per-page boot protect, all protected after reset
// R8 - Software unprotects boot pages before programming
// R9 - Boot lock set by reset, clear-only
// R10 - Boot protect writes need key unlock
// R11 - Program pages below bound are protected
// R12 - Program pages at-or-above bound are protected
// R13 - Bounds ignore low 12 address bits
// R14 - Bounds reset to no protection
// R15 - Program lock clear-only, freezes both bounds
// R16 - Program bound writes need key unlock
// R17 - Serves self-programming and debug requests
// R18 - Protected targets are refused, flash untouched
module fwp_flash_ctrl
  import fwp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  // Protection settings
  input  wire logic                     key_unlocked,
  input  wire logic                     wr_boot,
  input  wire logic                     wr_below,
  input  wire logic                     wr_above,
  input  wire logic [31:0]              wr_data,
  output logic      [31:0]              boot_rd,
  output logic      [31:0]              below_rd,
  output logic      [31:0]              above_rd,
  output logic                          wr_refused,
  // Operation requests
  input  wire logic                     runtime_self_programming_start,
  input  wire logic                     dsu_start,
  input  wire fwp_op_type               op_kind,
  input  wire logic                     op_boot,
  input  wire logic [`FWP_ADDR_W-1:0]   op_addr,
  input  wire logic [`FWP_QUAD_W-1:0]   op_wdata,
  input  wire logic [31:0]              op_src_addr,
  output logic                          op_busy,
  output logic                          op_done,
  output logic                          op_refused,
  output logic                          op_error,
  output logic                          op_by_debug,
  // SRAM fetch initiator
  output logic      [31:0]              haddr,
  output logic      [1:0]               htrans,
  output logic      [2:0]               hsize,
  output logic      [2:0]               hburst,
  output logic                          hwrite,
  input  wire logic [31:0]              hrdata,
  input  wire logic                     hready,
  input  wire logic                     hresp,
  // Flash array
  output logic                          flash_req,
  output fwp_op_type                    flash_cmd,
  output logic      [`FWP_ADDR_W-1:0]   flash_addr,
  output logic      [`FWP_QUAD_W-1:0]   flash_wdata,
  output logic      [3:0]               flash_wmask,
  input  wire logic                     flash_ack
);

  // ----------------------------------------------------------------
  // Protection registers
  // ----------------------------------------------------------------
  logic                       boot_lock;
  logic [`FWP_BOOT_PAGES-1:0] boot_prot;
  logic                       below_lock;
  logic                       above_lock;
  logic [`FWP_PAGE_W-1:0]     below_page;
  logic [`FWP_PAGE_W-1:0]     above_page;
  logic                       prog_open;
  logic                       boot_wr_ok;
  logic                       below_wr_ok;
  logic                       above_wr_ok;

  assign prog_open   = below_lock && above_lock; // R15
  assign boot_wr_ok  = wr_boot && key_unlocked && boot_lock; // R9 R10
  assign below_wr_ok = wr_below && key_unlocked && prog_open; // R16
  assign above_wr_ok = wr_above && key_unlocked && prog_open; // R16
  assign wr_refused  = ce && ((wr_boot && !boot_wr_ok) ||
                              (wr_below && !below_wr_ok) ||
                              (wr_above && !above_wr_ok));

  // Locks can only go from set to clear; a one written later is lost.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_lock <= 1'b1; // R9
      boot_prot <= `FWP_BOOT_RST; // R7
    end else if (ce && boot_wr_ok) begin
      boot_lock <= boot_lock && wr_data[`FWP_LOCK_BIT]; // R9
      boot_prot <= wr_data[`FWP_BOOT_PAGES-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      below_lock <= 1'b1;
      below_page <= `FWP_BELOW_RST; // R14
    end else if (ce && below_wr_ok) begin
      below_lock <= wr_data[`FWP_LOCK_BIT]; // R15
      below_page <= wr_data[`FWP_ADDR_W-1:`FWP_PAGE_LSB]; // R13
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      above_lock <= 1'b1;
      above_page <= `FWP_ABOVE_RST; // R14
    end else if (ce && above_wr_ok) begin
      above_lock <= wr_data[`FWP_LOCK_BIT]; // R15
      above_page <= wr_data[`FWP_ADDR_W-1:`FWP_PAGE_LSB]; // R13
    end
  end

  assign boot_rd  = {boot_lock, {(31-`FWP_BOOT_PAGES){1'b0}}, boot_prot};
  assign below_rd = {below_lock, {(31-`FWP_ADDR_W){1'b0}}, below_page,
                     {`FWP_PAGE_LSB{1'b0}}};
  assign above_rd = {above_lock, {(31-`FWP_ADDR_W){1'b0}}, above_page,
                     {`FWP_PAGE_LSB{1'b0}}};

  // ----------------------------------------------------------------
  // Request acceptance
  // ----------------------------------------------------------------
  fwp_state_type         state;
  fwp_state_type         next_state;
  logic                  prot_hit;
  logic                  start_any;
  logic                  accept;
  logic                  refuse;
  logic [`FWP_ADDR_W-1:0] req_addr;
  logic [31:0]           src_addr;
  logic [5:0]            quad_cnt;
  logic [1:0]            word_cnt;
  logic                  is_row;
  logic                  last_quad;
  logic                  word_in;
  logic                  quad_full;
  logic                  flash_fin;

  fwp_protect_check u_check (
    .addr       (op_addr),
    .in_boot    (op_boot),
    .boot_prot  (boot_prot),
    .below_page (below_page),
    .above_page (above_page),
    .prot_hit   (prot_hit)
  );

  // Requests arriving while busy are dropped; the debug port wins a tie.
  assign start_any = (runtime_self_programming_start || dsu_start) && (state == st_idle); // R17
  assign accept    = start_any && !prot_hit;
  assign refuse    = start_any && prot_hit; // R18
  assign is_row    = (flash_cmd == op_row);
  assign last_quad = (quad_cnt == 6'(`FWP_ROW_QUADS - 1)); // R2
  assign word_in   = (state == st_fetch_data) && hready && !hresp;
  assign quad_full = word_in && (word_cnt == 2'h3);
  assign flash_fin = (state == st_flash) && flash_ack;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      st_idle: begin
        if (accept) begin
          next_state = (op_kind == op_row) ? st_fetch_addr : st_flash;
        end
      end
      st_fetch_addr: begin
        if (hready) begin
          next_state = st_fetch_data;
        end
      end
      st_fetch_data: begin
        if (hready) begin
          if (hresp) begin
            next_state = st_idle;
          end else if (word_cnt == 2'h3) begin
            next_state = st_flash;
          end else begin
            next_state = st_fetch_addr;
          end
        end
      end
      st_flash: begin
        if (flash_ack) begin
          next_state = (is_row && !last_quad) ? st_fetch_addr : st_idle; // R2
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Operation latch and status pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_cmd   <= op_row;
      req_addr    <= '0;
      src_addr    <= '0;
      op_by_debug <= 1'b0;
    end else if (ce && accept) begin
      flash_cmd   <= op_kind; // R3 R5
      req_addr    <= op_addr;
      src_addr    <= op_src_addr;
      op_by_debug <= dsu_start; // R17
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_done    <= 1'b0;
      op_refused <= 1'b0;
      op_error   <= 1'b0;
    end else if (ce) begin
      op_done    <= flash_fin && (!is_row || last_quad);
      op_refused <= refuse; // R18
      op_error   <= (state == st_fetch_data) && hready && hresp;
    end
  end

  assign op_busy = (state != st_idle);

  // ----------------------------------------------------------------
  // Row fetch from SRAM, one word per single transfer
  // ----------------------------------------------------------------
  // Single transfers trade throughput for a trivially simple initiator.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quad_cnt <= '0;
      word_cnt <= '0;
    end else if (ce) begin
      if (accept) begin
        quad_cnt <= '0;
        word_cnt <= '0;
      end else begin
        if (word_in) begin
          word_cnt <= word_cnt + 2'h1;
        end
        if (flash_fin) begin
          quad_cnt <= quad_cnt + 6'h1;
        end
      end
    end
  end

  assign haddr  = src_addr + {22'h0, quad_cnt, word_cnt, 2'b00}; // R6
  assign htrans = (state == st_fetch_addr) ? `FWP_HTRANS_NSEQ
                                           : `FWP_HTRANS_IDLE; // R6
  assign hsize  = `FWP_HSIZE_WORD;
  assign hburst = `FWP_HBURST_SGL;
  assign hwrite = 1'b0;

  // ----------------------------------------------------------------
  // Flash command outputs
  // ----------------------------------------------------------------
  assign flash_req = (state == st_flash);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_addr  <= '0;
      flash_wdata <= '0;
      flash_wmask <= 4'h0;
    end else if (ce) begin
      if (accept) begin
        unique case (op_kind)
          op_row: begin
            flash_addr  <= {op_addr[`FWP_ADDR_W-1:`FWP_ROW_LSB],
                            {`FWP_ROW_LSB{1'b0}}}; // R4
            flash_wmask <= 4'hf;
          end
          op_quad: begin
            flash_addr  <= {op_addr[`FWP_ADDR_W-1:4], 4'h0}; // R3
            flash_wdata <= op_wdata;
            flash_wmask <= 4'hf;
          end
          op_word: begin
            flash_addr  <= {op_addr[`FWP_ADDR_W-1:2], 2'b00}; // R3
            flash_wdata <= {4{op_wdata[`FWP_WORD_W-1:0]}};
            flash_wmask <= 4'h1 << op_addr[3:2];
          end
          op_erase: begin
            flash_addr  <= {op_addr[`FWP_ADDR_W-1:`FWP_PAGE_LSB],
                            {`FWP_PAGE_LSB{1'b0}}}; // R1
            flash_wmask <= 4'h0;
          end
        endcase
      end else begin
        if (word_in) begin
          flash_wdata[word_cnt*`FWP_WORD_W +: `FWP_WORD_W] <= hrdata; // R4
        end
        if (quad_full) begin
          flash_addr <= {req_addr[`FWP_ADDR_W-1:`FWP_ROW_LSB], quad_cnt, 4'h0};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk iff ce);
  endclocking
  default disable iff (!rst_n);

  sequence quad_fetched_s;
    word_in && (word_cnt == 2'h3);
  endsequence

  sequence flash_issue_s;
    flash_req && (flash_cmd == op_row);
  endsequence

  boot_lock_sticky_a: assert property (!boot_lock |=> !boot_lock) // R9
    else $error("boot lock was set again");
  boot_frozen_a: assert property (!boot_lock |=> $stable(boot_prot)) // R9
    else $error("boot protection changed while locked");
  boot_key_gate_a: assert property (wr_boot && !key_unlocked |=> $stable(boot_rd)) // R10
    else $error("boot protection written without key");
  prog_key_gate_a: assert property ((wr_below || wr_above) && !key_unlocked
      |=> $stable(below_page) && $stable(above_page)) // R16
    else $error("program bound written without key");
  prog_frozen_a: assert property (!prog_open |=> !prog_open && $stable(below_rd)
      && $stable(above_rd)) // R15
    else $error("program protection changed after lock");
  refuse_prot_a: assert property (start_any && prot_hit
      |=> op_refused && (state == st_idle) && !flash_req) // R18
    else $error("protected target was not refused");
  row_fill_a: assert property (quad_fetched_s |=> flash_issue_s
      and (flash_addr[3:0] == 4'h0)) // R2 R6
    else $error("quad not issued after four fetched words");
  row_end_a: assert property (flash_fin && is_row && last_quad |=> op_done && !op_busy) // R2
    else $error("row did not end after its last quad");
  word_mask_a: assert property (flash_req && (flash_cmd == op_word)
      |-> $onehot(flash_wmask)) // R3
    else $error("single word write enables other lanes");
  erase_align_a: assert property (flash_req && (flash_cmd == op_erase)
      |-> (flash_addr[`FWP_PAGE_LSB-1:0] == '0)) // R1
    else $error("erase address not page aligned");

endmodule : fwp_flash_ctrl

`default_nettype wire

// file: testbench/fwp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// SRAM responder and flash array stand-in
// ------------------------------------------------------------
module fwp_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Behaviour knobs
  input  wire logic [2:0]  hwait,
  input  wire logic        herr,
  input  wire logic [3:0]  fdelay,
  // SRAM side
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  output logic      [31:0] hrdata,
  output logic             hready,
  output logic             hresp,
  // Flash side
  input  wire logic        flash_req,
  output logic             flash_ack
);
  logic        data_ph;
  logic [31:0] a_q;
  logic [31:0] last;
  logic [2:0]  wcnt;
  logic [3:0]  fcnt;
  logic        fin;

  assign fin    = data_ph && (wcnt == 3'h0);
  assign hready = !data_ph || fin;
  assign hresp  = fin && herr;
  // Outside a data beat the bus never repeats the previous word
  assign hrdata = fin ? {a_q[15:0], ~a_q[15:0]} : ~last;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_ph   <= 1'b0;
      a_q       <= 32'h0;
      last      <= 32'h0;
      wcnt      <= 3'h0;
      fcnt      <= 4'h0;
      flash_ack <= 1'b0;
    end else begin
      last <= hrdata;
      if (fin) begin
        data_ph <= 1'b0;
      end else if (data_ph) begin
        wcnt <= wcnt - 3'h1;
      end
      if (htrans == 2'h2 && hready) begin
        data_ph <= 1'b1;
        a_q     <= haddr;
        wcnt    <= hwait;
      end
      if (flash_req && !flash_ack) begin
        if (fcnt == fdelay) begin
          flash_ack <= 1'b1;
        end else begin
          fcnt <= fcnt + 4'h1;
        end
      end else begin
        flash_ack <= 1'b0;
        fcnt      <= 4'h0;
      end
    end
  end
endmodule : fwp_mem_model
`default_nettype wire

// file: testbench/test_flash_write_protect_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "fwp_defines.svh"
module test_flash_write_protect_ctrl
  import fwp_pkg::*;
;
  logic clk, rst_n, ce, key_unlocked, wr_boot, wr_below, wr_above, wr_refused;
  logic [31:0] wr_data, boot_rd, below_rd, above_rd, op_src_addr, haddr, hrdata;
  logic runtime_self_programming_start, dsu_start, op_boot, op_busy, op_done, op_refused, op_error;
  logic op_by_debug, hwrite, hready, hresp, flash_req, flash_ack, herr;
  logic [23:0] op_addr, flash_addr;
  logic [127:0] op_wdata, flash_wdata;
  logic [1:0] htrans;
  logic [2:0] hsize, hburst, hwait;
  logic [3:0] flash_wmask, fdelay;
  fwp_op_type op_kind, flash_cmd;
  int seed, bad_count, comparisons;
  logic s_bl, s_ll, s_al;
  logic [7:0] s_bp;
  logic [11:0] s_lo, s_hi;

  fwp_flash_ctrl uut (.clk, .rst_n, .ce, .key_unlocked, .wr_boot, .wr_below, .wr_above,
    .wr_data, .boot_rd, .below_rd, .above_rd, .wr_refused, .runtime_self_programming_start, .dsu_start,
    .op_kind, .op_boot, .op_addr, .op_wdata, .op_src_addr, .op_busy, .op_done,
    .op_refused, .op_error, .op_by_debug, .haddr, .htrans, .hsize, .hburst, .hwrite,
    .hrdata, .hready, .hresp, .flash_req, .flash_cmd, .flash_addr, .flash_wdata,
    .flash_wmask, .flash_ack);
  fwp_mem_model partner (.clk, .rst_n, .hwait, .herr, .fdelay, .haddr, .htrans,
    .hrdata, .hready, .hresp, .flash_req, .flash_ack);

  always #4 clk = ~clk;

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] word(input logic [31:0] x);
    return {x[15:0], ~x[15:0]};
  endfunction : word

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic do_reset;
    @(negedge clk);
    rst_n = 1'b0;
    {s_bl, s_ll, s_al, s_bp, s_lo, s_hi} = {3'h7, 8'hff, 12'h000, 12'hfff};
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk(boot_rd, 32'h800000ff);
    chk(below_rd, 32'h80000000);
    chk(above_rd, 32'h80fff000);
  endtask : do_reset

  // Shadow copy of the protection settings drives every expectation
  task automatic wr(input int which, input logic [31:0] d, input logic key);
    logic ok;
    ok = key && (which == 0 ? s_bl : (s_ll && s_al));
    @(negedge clk);
    key_unlocked = key;
    wr_data = d;
    wr_boot = (which == 0);
    wr_below = (which == 1);
    wr_above = (which == 2);
    #1 chk(wr_refused, !ok);
    @(negedge clk);
    {wr_boot, wr_below, wr_above} = 3'h0;
    if (ok && which == 0) {s_bl, s_bp} = {s_bl & d[31], d[7:0]};
    if (ok && which == 1) {s_ll, s_lo} = {s_ll & d[31], d[23:12]};
    if (ok && which == 2) {s_al, s_hi} = {s_al & d[31], d[23:12]};
    chk(boot_rd, {s_bl, 23'h0, s_bp});
    chk(below_rd, {s_ll, 7'h0, s_lo, 12'h0});
    chk(above_rd, {s_al, 7'h0, s_hi, 12'h0});
  endtask : wr

  task automatic op(input fwp_op_type k, input logic bt, input logic [23:0] a,
                    input logic dbg);
    logic [127:0] w;
    logic [31:0]  b;
    logic [31:0]  src;
    logic         prot;
    int           i;
    int           n;
    w = {$random(seed), $random(seed), $random(seed), $random(seed)};
    src = 32'h20000000 | (32'($random(seed)) & 32'h0000fffc);
    hwait = 3'($random(seed));
    fdelay = 4'($random(seed)) & 4'h3;
    prot = bt ? s_bp[a[14:12]]
              : (a[23:12] < s_lo || (s_hi != 12'hfff && a[23:12] >= s_hi));
    @(negedge clk);
    {op_kind, op_boot, op_addr, op_wdata, op_src_addr} = {k, bt, a, w, src};
    runtime_self_programming_start = !dbg;
    dsu_start = dbg;
    @(negedge clk);
    {runtime_self_programming_start, dsu_start} = 2'h0;
    i = 0;
    n = 0;
    while (!(op_done || op_refused || op_error) && n < 3000) begin
      if (flash_ack) begin
        b = src + 32'(16 * i);
        chk(flash_cmd, k);
        if (k == op_row) begin
          chk(flash_addr, a + 24'(16 * i));
          chk(flash_wdata, {word(b + 12), word(b + 8), word(b + 4), word(b)});
        end else if (k != op_erase) begin
          chk(flash_addr, a);
          chk(flash_wdata, k == op_word ? {4{w[31:0]}} : w);
        end
        if (k != op_erase) chk(flash_wmask, k == op_word ? 4'h1 << a[3:2] : 4'hf);
        i++;
      end
      n++;
      @(negedge clk);
    end
    chk(n < 3000, 1'b1);
    chk(op_refused, prot);
    chk(op_error, !prot && herr && k == op_row);
    chk(op_done, !prot && !(herr && k == op_row));
    chk(i, (prot || herr) ? 0 : (k == op_row ? 64 : 1));
    if (!prot) chk(op_by_debug, dbg);
  endtask : op

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] r;
    fwp_op_type  k;
    logic [23:0] a;
    {clk, ce, key_unlocked, wr_boot, wr_below, wr_above, wr_data} = {2'h1, 36'h0};
    {runtime_self_programming_start, dsu_start, op_boot, op_addr, op_wdata, op_src_addr} = 188'h0;
    {op_kind, hwait, herr, fdelay, rst_n} = {op_quad, 3'h0, 1'b0, 4'h0, 1'b1};
    seed = 69;
    do_reset();
    wr(0, 32'h800000f0, 1'b0);
    wr(2, 32'h80008000, 1'b0);
    op(op_quad, 1'b1, 24'h001000, 1'b0);
    wr(0, 32'h800000f0, 1'b1);
    for (int j = 0; j < 4; j++) op(fwp_op_type'(j), 1'b1, 24'h001400, j[0]);
    op(op_word, 1'b1, 24'h00300c, 1'b1);
    op(op_quad, 1'b1, 24'h005000, 1'b0);
    wr(1, 32'h80003abc, 1'b1);
    wr(2, 32'h80008fff, 1'b1);
    op(op_quad, 1'b0, 24'h002ff0, 1'b0);
    op(op_quad, 1'b0, 24'h003000, 1'b1);
    op(op_quad, 1'b0, 24'h007ff0, 1'b0);
    op(op_quad, 1'b0, 24'h008000, 1'b1);
    for (int j = 0; j < 16; j++) begin
      r = $random(seed);
      k = fwp_op_type'(r[17:16]);
      a = {8'h00, r[15:12], r[11:2], 2'b00};
      if (k == op_row) a[9:0] = 10'h0;
      if (k == op_quad) a[3:0] = 4'h0;
      op(k, 1'b0, a, r[20]);
    end
    herr = 1'b1;
    op(op_row, 1'b0, 24'h004800, 1'b0);
    herr = 1'b0;
    wr(1, 32'h00005000, 1'b1);
    wr(2, 32'h80009000, 1'b1);
    wr(1, 32'h80001000, 1'b1);
    op(op_quad, 1'b0, 24'h004000, 1'b0);
    wr(0, 32'h000000ff, 1'b1);
    wr(0, 32'h80000000, 1'b1);
    do_reset();
    wr(1, 32'h80002000, 1'b1);
    finish_test();
  end

  initial begin
    #600000;
    bad_count++;
    finish_test();
  end
endmodule : test_flash_write_protect_ctrl
`default_nettype wire
